// *** hdl/glitch_filter.sv ***
`timescale 1ns/1ps
// Holds the output until the input has been stable for the chosen delay
module glitch_filter #(
    parameter int CNT_W = 8
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_sys_rst,
    // Data
    input  wire logic             i_raw,
    input  wire logic [CNT_W-1:0] i_delay,
    output      logic             o_filtered
);
    logic [CNT_W-1:0] stable_cnt_r;

    // Elaboration check: a one-bit count cannot hold any delay
    if (CNT_W < 2)
    begin : g_bad_cnt_w
        $error("glitch_filter: CNT_W too small");
    end

    // Count disagreement; any agreement restarts the count
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            stable_cnt_r <= '0;
            o_filtered   <= 1'b0;
        end
        else if (i_raw == o_filtered)
            stable_cnt_r <= '0;
        else if (stable_cnt_r + CNT_W'(1) >= i_delay)
        begin
            stable_cnt_r <= '0;
            o_filtered   <= i_raw;
        end
        else
            stable_cnt_r <= stable_cnt_r + CNT_W'(1);
    end
endmodule

// *** hdl/ocp_pkg.sv ***
package ocp_pkg;
    // Widths
    localparam int SENSE_W       = 10;
    localparam int PWM_CNT_W     = 16;
    // Reference levels in millivolts and sense full scale
    localparam int REF_1V5_MV    = 1500;
    localparam int REF_2V0_MV    = 2000;
    localparam int REF_2V5_MV    = 2500;
    localparam int FULL_SCALE_MV = 3300;
    // Threshold select encodings
    localparam logic [1:0] SEL_1V5 = 2'h0;
    localparam logic [1:0] SEL_2V0 = 2'h1;
    localparam logic [1:0] SEL_2V5 = 2'h2;
    // Filter delay steps in ns, four settings
    localparam int FILT0_NS      = 100;
    localparam int FILT1_NS      = 300;
    localparam int FILT2_NS      = 600;
    localparam int FILT3_NS      = 1000;
    localparam int CLK_MHZ       = 50;
    localparam int FILT0_CYC     = (FILT0_NS * CLK_MHZ + 999) / 1000;
    localparam int FILT1_CYC     = (FILT1_NS * CLK_MHZ + 999) / 1000;
    localparam int FILT2_CYC     = (FILT2_NS * CLK_MHZ + 999) / 1000;
    localparam int FILT3_CYC     = (FILT3_NS * CLK_MHZ + 999) / 1000;
    // Reset values
    localparam logic [2:0] LOW_SIDE_RST  = 3'h0;
    localparam logic [2:0] HIGH_SIDE_RST = 3'h0;

    // Comparator configuration bundle
    typedef struct packed {
        logic       comparator_on_bit;
        logic       comparator_filter_bit;
        logic [1:0] filter_delay_sel;
        logic [1:0] threshold_select_field;
    } comparator_control_two_s;

    // Timer event control configuration bundle
    typedef struct packed {
        logic fault_enable;
        logic fault_irq_enable;
        logic clear_ext_enable;
        logic clear_int_enable;
        logic clear_irq_enable;
    } timer_event_control_s;

    // Interrupt vector codes
    typedef enum logic [1:0] {
        VEC_NONE  = 2'b00,
        VEC_FAULT = 2'b01,
        VEC_CLEAR = 2'b10
    } irq_vec_e;
endpackage

// *** hdl/overcurrent_pwm_cutoff.sv ***
`timescale 1ns/1ps
module overcurrent_pwm_cutoff #(
    parameter int SENSE_W = ocp_pkg::SENSE_W,
    parameter int CNT_W   = ocp_pkg::PWM_CNT_W
) (
    // Clock and reset
    input  wire logic                                   i_clk,
    input  wire logic                                   i_sys_rst,
    // Current sense, digitised, full scale = 3.3 V
    input  wire logic [SENSE_W-1:0]                     i_sense_input_channel,
    // Comparator configuration
    input  wire ocp_pkg::comparator_control_two_s       i_cmp_ctl,
    // PWM timer configuration
    input  wire logic                                   i_pwm_enable,
    input  wire logic [CNT_W-1:0]                       i_pwm_period,
    input  wire logic [CNT_W-1:0]                       i_pwm_duty,
    input  wire logic [2:0]                             i_phase_select,
    // Firmware low-side outputs
    input  wire logic [2:0]                             i_low_side_gpio,
    // Timer event control
    input  wire ocp_pkg::timer_event_control_s          i_tec_ctl,
    input  wire logic                                   i_ext_clear,
    input  wire logic                                   i_flag_clear_fault,
    input  wire logic                                   i_flag_clear_clear,
    // Gate drive
    output      logic [2:0]                             o_high_side_gate,
    output      logic [2:0]                             o_low_side_gate,
    // Status
    output      logic                                   o_comparator_output,
    output      logic                                   o_fault_input_one,
    output      logic                                   o_fault_flag,
    output      logic                                   o_clear_flag,
    output      logic                                   o_irq,
    output      ocp_pkg::irq_vec_e                      o_irq_vec
);
    localparam logic [SENSE_W-1:0] REF_1V5 = SENSE_W'(
        (ocp_pkg::REF_1V5_MV * (2 ** SENSE_W)) / ocp_pkg::FULL_SCALE_MV);
    localparam logic [SENSE_W-1:0] REF_2V0 = SENSE_W'(
        (ocp_pkg::REF_2V0_MV * (2 ** SENSE_W)) / ocp_pkg::FULL_SCALE_MV);
    localparam logic [SENSE_W-1:0] REF_2V5 = SENSE_W'(
        (ocp_pkg::REF_2V5_MV * (2 ** SENSE_W)) / ocp_pkg::FULL_SCALE_MV);
    localparam int FILT_W = 8;

    // Elaboration checks on widths the logic cannot serve
    if (SENSE_W < 4 || SENSE_W > 16)
    begin : g_bad_sense_w
        $error("overcurrent_pwm_cutoff: SENSE_W out of range");
    end
    if (CNT_W < 4)
    begin : g_bad_cnt_w
        $error("overcurrent_pwm_cutoff: CNT_W too small");
    end
    if (ocp_pkg::FILT3_CYC >= 2 ** FILT_W)
    begin : g_bad_filt_w
        $error("overcurrent_pwm_cutoff: filter count too wide");
    end

    logic [SENSE_W-1:0] reference_level;
    logic               raw_compare;
    logic [FILT_W-1:0]  filter_delay;
    logic               filtered_compare;
    logic               comparator_output_r;
    logic               fault_live;
    logic [CNT_W-1:0]   pwm_cnt_r;
    logic               pwm_on_r;
    logic               timer_clear;
    logic               int_clear_evt;
    logic               ext_clear_evt;
    logic               fault_rise;
    logic               fault_prev_r;
    logic               fault_flag_r;
    logic               clear_flag_r;

    // Threshold from the reference select field; spare code keeps 2.5 V
    always_comb
    begin
        unique case (i_cmp_ctl.threshold_select_field)
            ocp_pkg::SEL_1V5: reference_level = REF_1V5;
            ocp_pkg::SEL_2V0: reference_level = REF_2V0;
            default:          reference_level = REF_2V5;
        endcase
    end

    // Sense on plus side, reference on minus side; off means low
    assign raw_compare = i_cmp_ctl.comparator_on_bit
        && (i_sense_input_channel > reference_level);

    // Four filter delays, converted to clock cycles
    always_comb
    begin
        unique case (i_cmp_ctl.filter_delay_sel)
            2'h0:    filter_delay = FILT_W'(ocp_pkg::FILT0_CYC);
            2'h1:    filter_delay = FILT_W'(ocp_pkg::FILT1_CYC);
            2'h2:    filter_delay = FILT_W'(ocp_pkg::FILT2_CYC);
            default: filter_delay = FILT_W'(ocp_pkg::FILT3_CYC);
        endcase
    end

    glitch_filter #(
        .CNT_W      (FILT_W)
    ) u_filter (
        .i_clk      (i_clk),
        .i_sys_rst  (i_sys_rst),
        .i_raw      (raw_compare),
        .i_delay    (filter_delay),
        .o_filtered (filtered_compare)
    );

    // Registered comparator output, so the status port is a flop
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            comparator_output_r <= 1'b0;
        else if (i_cmp_ctl.comparator_filter_bit)
            comparator_output_r <= filtered_compare;
        else
            comparator_output_r <= raw_compare;
    end

    assign o_comparator_output = comparator_output_r;
    // Comparator output is the fault input one of the event control
    assign o_fault_input_one = comparator_output_r;
    assign fault_live = comparator_output_r && i_tec_ctl.fault_enable;

    // Internal clear at period end, external clear when enabled; with the
    // internal clear off the counter runs through its full width
    assign int_clear_evt = i_tec_ctl.clear_int_enable
        && (pwm_cnt_r >= i_pwm_period);
    assign ext_clear_evt = i_tec_ctl.clear_ext_enable
        && i_ext_clear;
    assign timer_clear   = int_clear_evt || ext_clear_evt;

    // High-side timer instance: edge-aligned counter
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst || !i_pwm_enable)
            pwm_cnt_r <= '0;
        else if (timer_clear)
            pwm_cnt_r <= '0;
        else
            pwm_cnt_r <= pwm_cnt_r + CNT_W'(1);
    end

    // Compare output of the timer, before fault gating
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst || !i_pwm_enable)
            pwm_on_r <= 1'b0;
        else
            pwm_on_r <= (pwm_cnt_r < i_pwm_duty);
    end

    // Gating is combinational so the fault wins in its own cycle; the
    // counter keeps running, so PWM resumes phase-aligned by itself
    always_comb
    begin
        o_high_side_gate = 3'h0;
        if (pwm_on_r && !fault_live)
            o_high_side_gate = i_phase_select;
    end

    // Low side from firmware pins only, not the timer
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            o_low_side_gate <= ocp_pkg::LOW_SIDE_RST;
        else
            o_low_side_gate <= i_low_side_gpio;
    end

    // Previous fault level for rising edge detection
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            fault_prev_r <= 1'b0;
        else
            fault_prev_r <= fault_live;
    end

    // Only a fresh fault raises the flag, not one that persists
    assign fault_rise = fault_live && !fault_prev_r;

    // Sticky fault flag; a new event wins over a clear
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            fault_flag_r <= 1'b0;
        else if (fault_rise)
            fault_flag_r <= 1'b1;
        else if (i_flag_clear_fault)
            fault_flag_r <= 1'b0;
    end

    // Sticky clear-event flag; a new event wins over a clear
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            clear_flag_r <= 1'b0;
        else if (ext_clear_evt)
            clear_flag_r <= 1'b1;
        else if (i_flag_clear_clear)
            clear_flag_r <= 1'b0;
    end

    assign o_fault_flag = fault_flag_r;
    assign o_clear_flag = clear_flag_r;

    // Vector gives fault priority over clear
    always_comb
    begin
        if (fault_flag_r && i_tec_ctl.fault_irq_enable)
            o_irq_vec = ocp_pkg::VEC_FAULT;
        else if (clear_flag_r && i_tec_ctl.clear_irq_enable)
            o_irq_vec = ocp_pkg::VEC_CLEAR;
        else
            o_irq_vec = ocp_pkg::VEC_NONE;
    end

    assign o_irq = (o_irq_vec != ocp_pkg::VEC_NONE);
endmodule

// *** verification/ocp_sense_src.sv ***
`timescale 1ns/1ps
// Amplified shunt voltage as the sense channel sees it, 3.3 V full scale
module ocp_sense_src (
    // Requested sense voltage in millivolts
    input  wire logic [11:0] i_mv,
    // Code on the comparator plus input
    output      logic [9:0]  o_code
);
    // Saturates at full scale, as the real amplifier rails out there
    always_comb
    begin
        if (i_mv >= 12'hce4)
            o_code = 10'h3ff;
        else
            o_code = 10'((32'(i_mv) * 1024) / 3300);
    end
endmodule

// *** verification/overcurrent_pwm_cutoff_bench.sv ***
`timescale 1ns/1ps
module overcurrent_pwm_cutoff_bench;
    logic                             clk, rst, ext, fcf, fcc, ec, mon;
    logic [9:0]                       sense;
    logic [11:0]                      mv;
    logic [15:0]                      duty;
    logic [2:0]                       ph, gpio, hg, lg, el;
    logic                             co, fi, ff, cf, irq;
    ocp_pkg::comparator_control_two_s cc;
    ocp_pkg::timer_event_control_s    tc;
    ocp_pkg::irq_vec_e                vec;
    int                               failures, n_compared, n, mcnt;
    int unsigned                      rs;
    int                               fc[4] = '{ocp_pkg::FILT0_CYC,
        ocp_pkg::FILT1_CYC, ocp_pkg::FILT2_CYC, ocp_pkg::FILT3_CYC};

    ocp_sense_src src_u (.i_mv(mv), .o_code(sense));
    overcurrent_pwm_cutoff dut_u (.i_clk(clk), .i_sys_rst(rst),
        .i_sense_input_channel(sense), .i_cmp_ctl(cc), .i_pwm_enable(1'b1),
        .i_pwm_period(16'h0009), .i_pwm_duty(duty), .i_phase_select(ph),
        .i_low_side_gpio(gpio), .i_tec_ctl(tc), .i_ext_clear(ext),
        .i_flag_clear_fault(fcf), .i_flag_clear_clear(fcc),
        .o_high_side_gate(hg), .o_low_side_gate(lg),
        .o_comparator_output(co), .o_fault_input_one(fi), .o_fault_flag(ff),
        .o_clear_flag(cf), .o_irq(irq), .o_irq_vec(vec));

    function automatic int unsigned xs(int unsigned x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    // Reference threshold as a sense code
    function automatic int thr(logic [1:0] s);
        return (s == 2'h0 ? ocp_pkg::REF_1V5_MV : s == 2'h1 ?
            ocp_pkg::REF_2V0_MV : ocp_pkg::REF_2V5_MV) * 1024 / 3300;
    endfunction
    task chk(string nm, logic [2:0] e, logic [2:0] g);
        n_compared++;
        if (g !== e)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task test_done;
        if (failures == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Free-running 50 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Hang guard, generous against roughly 670 cycles of tests
    initial
    begin
        #(20 * 3000);
        failures++;
        test_done();
    end
    // Main sequence, all inputs moved on the falling edge
    initial
    begin
        rst = 1'b1;
        ext = 1'b0;
        fcf = 1'b0;
        fcc = 1'b0;
        mv = 12'h000;
        ph = 3'h1;
        gpio = 3'h0;
        duty = 16'h0004;
        cc = 6'h20;
        tc = 5'h1f; // All event enables and both interrupt enables on
        rs = 85;
        ec = 1'b0;
        el = 3'h0;
        mcnt = 0;
        mon = 1'b0;
        repeat (6) @(posedge clk);
        @(negedge clk) rst = 0;
        // Random sweep, unfiltered, model result one cycle behind
        repeat (300)
        begin
            @(negedge clk);
            chk("cmp", {2'h0, ec}, {2'h0, co});
            chk("fault_in", {2'h0, ec}, {2'h0, fi});
            chk("low", el, lg);
            if (fi === 1'b1) chk("blank", 3'h0, hg);
            chk("leg", 3'h0, hg & ~ph);
            // Timer model for the edge just passed, counting 0..9
            mon = (mcnt < int'(duty));
            mcnt = (mcnt >= 9) ? 0 : mcnt + 1;
            chk("pwm", (mon && !ec) ? ph : 3'h0, hg);
            rs = xs(rs);
            mv = 12'(rs % 3300);
            cc = {rs[14] | rs[15], 1'b0, 2'h0, rs[13:12]};
            gpio = rs[18:16];
            ph = rs[21:19];
            duty = 16'(rs[25:22]);
            ec = cc.comparator_on_bit && mv * 1024 / 3300 > thr(rs[13:12]);
            el = gpio;
        end
        // Overcurrent walk: blank, flag, then self resume
        @(negedge clk);
        mv = 12'h000;
        ph = 3'h5;
        duty = 16'hffff;
        fcf = 1'b1;
        cc = 6'h22;
        repeat (2) @(negedge clk);
        fcf = 0;
        @(negedge clk);
        chk("irq", 3'h0, {ff, irq, 1'b0});
        mv = 12'hbb8;
        @(negedge clk);
        chk("blank", 3'h0, hg);
        @(negedge clk);
        chk("fault", 3'h7, {ff, irq, 1'b1});
        chk("vec", ocp_pkg::VEC_FAULT, vec);
        mv = 0;
        repeat (3) @(negedge clk);
        chk("resume", ph, hg);
        // Fault input disabled: overcurrent must not blank
        tc.fault_enable = 0;
        mv = 12'hbb8;
        repeat (2) @(negedge clk);
        chk("no_blank", ph, hg);
        mv = 0;
        repeat (2) @(negedge clk);
        // Clear event and both flag clears in one cycle: the event wins
        tc.fault_enable = 1'b1;
        fcf = 1'b1;
        fcc = 1'b1;
        ext = 1'b1;
        @(negedge clk);
        fcf = 1'b0;
        fcc = 1'b0;
        ext = 1'b0;
        @(negedge clk);
        chk("clr", 3'h6, {cf, irq, ff});
        chk("vec", ocp_pkg::VEC_CLEAR, vec);
        // Clear-flag clear alone drops the flag and its interrupt
        fcc = 1'b1;
        @(negedge clk);
        fcc = 1'b0;
        chk("flag_clear", 3'h0, {cf, irq, ff});
        chk("vec", ocp_pkg::VEC_NONE, vec);
        // Each of the four filter delays
        for (int d = 0; d < 4; d++)
        begin
            cc = {1'b1, 1'b1, 2'(d), 2'h2};
            mv = 12'h000;
            repeat (60) @(negedge clk);
            mv = 12'hbb8; n = 0;
            while (co !== 1'b1 && n < 80)
            begin
                @(negedge clk);
                n++;
            end
            chk("filt", 3'h1, {2'h0, n == fc[d] + 1});
        end
        test_done();
    end
endmodule

// *** verification/overcurrent_pwm_cutoff_props.sv ***
`timescale 1ns/1ps
module ocp_props #(
    parameter int SENSE_W = 10
) (
    input wire logic                             i_clk,
    input wire logic                             i_sys_rst,
    input wire logic [SENSE_W-1:0]               i_sense_input_channel,
    input wire ocp_pkg::comparator_control_two_s i_cmp_ctl,
    input wire logic [2:0]                       i_phase_select,
    input wire logic [2:0]                       i_low_side_gpio,
    input wire ocp_pkg::timer_event_control_s    i_tec_ctl,
    input wire logic                             i_ext_clear,
    input wire logic [2:0]                       o_high_side_gate,
    input wire logic [2:0]                       o_low_side_gate,
    input wire logic                             o_comparator_output,
    input wire logic                             o_fault_input_one,
    input wire logic                             o_fault_flag,
    input wire logic                             o_clear_flag,
    input wire logic                             o_irq,
    input wire ocp_pkg::irq_vec_e                o_irq_vec
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    logic [9:0] thr;
    // Threshold codes for 1.5, 2.0 and 2.5 V; code 3 reads as 2.5 V
    assign thr = (i_cmp_ctl.threshold_select_field == 2'h0) ? 10'h1d1 :
                 (i_cmp_ctl.threshold_select_field == 2'h1) ? 10'h26c : 10'h307;

    property p_cmp; !i_cmp_ctl.comparator_filter_bit |=> o_comparator_output
        == $past(i_cmp_ctl.comparator_on_bit && i_sense_input_channel > thr);
    endproperty
    a_cmp: assert property (p_cmp) else $error("compare wrong");
    property p_route; o_fault_input_one == o_comparator_output; endproperty
    a_route: assert property (p_route) else $error("fault route");
    property p_blank; o_fault_input_one && i_tec_ctl.fault_enable
        |-> o_high_side_gate == 3'h0; endproperty
    a_blank: assert property (p_blank) else $error("not blanked");
    property p_leg; (o_high_side_gate & ~i_phase_select) == 3'h0; endproperty
    a_leg: assert property (p_leg) else $error("wrong leg");
    property p_low; !i_sys_rst |=> o_low_side_gate == $past(i_low_side_gpio);
    endproperty
    a_low: assert property (p_low) else $error("low side");
    property p_flag; $rose(o_fault_input_one) && i_tec_ctl.fault_enable
        |=> o_fault_flag; endproperty
    a_flag: assert property (p_flag) else $error("fault flag");
    property p_clr; i_ext_clear && i_tec_ctl.clear_ext_enable |=> o_clear_flag;
    endproperty
    a_clr: assert property (p_clr) else $error("clear flag");
    property p_irq; o_fault_flag && i_tec_ctl.fault_irq_enable |-> o_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("no irq");
    property p_quiet; !o_fault_flag && !o_clear_flag
        |-> !o_irq && o_irq_vec == ocp_pkg::VEC_NONE; endproperty
    a_quiet: assert property (p_quiet) else $error("stray irq");
endmodule
bind overcurrent_pwm_cutoff ocp_props #(.SENSE_W(SENSE_W)) props_u (
    .i_clk, .i_sys_rst, .i_sense_input_channel, .i_cmp_ctl, .i_phase_select,
    .i_low_side_gpio, .i_tec_ctl, .i_ext_clear, .o_high_side_gate,
    .o_low_side_gate, .o_comparator_output, .o_fault_input_one,
    .o_fault_flag, .o_clear_flag, .o_irq, .o_irq_vec);
